// [frr_pkg.sv]
// Package for the fault record, auto-restart and alert register logic.
// Assumes one 10 MHz system clock shared by every user of these constants.
package frr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] FRR_REC_CTL_OFS   = 8'h90;
  localparam logic [7:0] FRR_RESTART_OFS   = 8'ha2;
  localparam logic [7:0] FRR_MASK_BASE_OFS = 8'h15;
  localparam int         FRR_MASK_REGS     = 6;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FRR_REC_EN_BIT     = 7;
  localparam int FRR_REC_UNLOCK_BIT = 6;
  localparam int FRR_REC_BEGUN_BIT  = 5;
  localparam int FRR_REC_DONE_BIT   = 4;
  localparam int FRR_REC_ALERT_BIT  = 3;
  localparam int FRR_RST_EN_BIT     = 7;
  localparam int FRR_RST_DL_LSB     = 4;
  localparam int FRR_RST_HOLD_BIT   = 1;
  localparam int FRR_RST_WP_BIT     = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] FRR_REC_CTL_RST = 8'h00;
  localparam logic [7:0] FRR_RESTART_RST = 8'h00;
  localparam logic [7:0] FRR_MASK_RST    = 8'h00;

  // ****************************************
  // Record layout in nonvolatile memory
  // ****************************************
  localparam logic [7:0] FRR_NV_FLAG_BASE = 8'ha4;
  localparam logic [7:0] FRR_NV_MEAS_BASE = 8'he1;
  localparam int         FRR_FLAG_BYTES   = 6;
  localparam int         FRR_MEAS_BYTES   = 6;
  localparam int         FRR_REC_BYTES    = FRR_FLAG_BYTES + FRR_MEAS_BYTES;

  // ****************************************
  // Timing
  // ****************************************
  localparam int FRR_CLK_KHZ          = 10000;
  localparam int FRR_RESTART_BASE_US  = 512000;
  localparam int FRR_RESTART_BASE_CYC = FRR_RESTART_BASE_US / 1000 * FRR_CLK_KHZ;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic       enable;
    logic       unlock;
    logic       begun;
    logic       done;
    logic       alert_mask;
  } frr_rec_ctl_s;

  typedef struct packed {
    logic       auto_restart_enable;
    logic [2:0] auto_restart_delay_sel;
  } frr_restart_ctl_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } frr_nv_s;

  typedef enum logic {FRR_REC_IDLE, FRR_REC_COPY} frr_rec_state_e;

endpackage

// [frr_regs.sv]
// Fault record control, auto-restart timing and alert gating registers.
// Assumes the serial-port engine presents byte reads and writes on the reg
// port synchronously, and a nonvolatile write engine accepts one byte per ack.
`timescale 1ns/1ns
module frr_regs
  import frr_pkg::*;
#(
  parameter int RESTART_BASE_CYC = FRR_RESTART_BASE_CYC
)(
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [7:0]           reg_rdata_out,
  input  wire logic                 fault_event_in,
  input  wire logic [7:0]           fault_flags_in,
  input  wire logic [4:0][7:0]      alarm_flags_in,
  input  wire logic [5:0][7:0]      meas_msb_in,
  output logic                      nv_req_out,
  output frr_nv_s                   nv_out,
  input  wire logic                 nv_ack_in,
  input  wire logic [1:0]           meter_flags_in,
  input  wire logic [1:0]           meter_alert_mask_in,
  input  wire logic                 conv_done_in,
  input  wire logic                 conversion_alert_mask_in,
  output logic                      alert_req_out,
  input  wire logic                 restart_cmd_in,
  input  wire logic                 cooling_in,
  input  wire logic                 latchoff_in,
  output logic                      turn_on_out,
  input  wire logic                 wp_pin_in
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic mask_hit(input logic [7:0] a);
    mask_hit = (a >= FRR_MASK_BASE_OFS) &&
               (a < FRR_MASK_BASE_OFS + 8'(FRR_MASK_REGS));
  endfunction

  function automatic logic [2:0] mask_idx(input logic [7:0] a);
    mask_idx = 3'(a - FRR_MASK_BASE_OFS);
  endfunction

  function automatic logic [7:0] nv_addr(input logic [3:0] i);
    if (i < 4'(FRR_FLAG_BYTES))
      nv_addr = FRR_NV_FLAG_BASE + 8'(i);
    else
      nv_addr = FRR_NV_MEAS_BASE + 8'(i) - 8'(FRR_FLAG_BYTES);
  endfunction

  // ****************************************
  // Register state
  // ****************************************
  frr_rec_ctl_s                          rec_r, rec_nxt;
  frr_restart_ctl_s                      rst_r, rst_nxt;
  logic [FRR_MASK_REGS-1:0][7:0]         mask_r, mask_nxt;
  logic [7:0]                            rdata_r, rdata_nxt;
  frr_rec_state_e                        st_r, st_nxt;
  logic [3:0]                            idx_r, idx_nxt;
  logic [FRR_REC_BYTES-1:0][7:0]         snap_r, snap_nxt;
  frr_nv_s                               nv_r, nv_nxt;
  logic                                  cnt_on_r, cnt_on_nxt;
  logic [31:0]                           cnt_r, cnt_nxt;
  logic                                  on_r, on_nxt;
  logic                                  wr_rec, wr_rst, rec_start, rec_last, permit;
  logic                                  holdoff;
  logic [7:0]                            rec_rd, rst_rd;

  assign wr_rec    = reg_wr_in && (reg_addr_in == FRR_REC_CTL_OFS);
  assign wr_rst    = reg_wr_in && (reg_addr_in == FRR_RESTART_OFS);
  // Permit taken from the stored bit or the same write, so one write rearms
  assign permit    = rec_r.unlock || reg_wdata_in[FRR_REC_UNLOCK_BIT];
  assign rec_start = fault_event_in && rec_r.enable && !rec_r.begun && !rec_r.done &&
                     (st_r == FRR_REC_IDLE);
  assign rec_last  = (st_r == FRR_REC_COPY) && nv_ack_in &&
                     (idx_r == 4'(FRR_REC_BYTES - 1));
  assign holdoff   = cnt_on_r || cooling_in || latchoff_in;

  always_comb
  begin
    rec_rd = 8'h00;
    rec_rd[FRR_REC_EN_BIT]     = rec_r.enable;
    rec_rd[FRR_REC_UNLOCK_BIT] = rec_r.unlock;
    rec_rd[FRR_REC_BEGUN_BIT]  = rec_r.begun;
    rec_rd[FRR_REC_DONE_BIT]   = rec_r.done;
    rec_rd[FRR_REC_ALERT_BIT]  = rec_r.alert_mask;
    rst_rd = 8'h00;
    rst_rd[FRR_RST_EN_BIT]                     = rst_r.auto_restart_enable;
    rst_rd[FRR_RST_DL_LSB+2:FRR_RST_DL_LSB]    = rst_r.auto_restart_delay_sel;
    rst_rd[FRR_RST_HOLD_BIT]                   = holdoff;
    rst_rd[FRR_RST_WP_BIT]                     = wp_pin_in;
  end

  // ****************************************
  // Register file and record sequencer
  // ****************************************
  always_comb
  begin
    rec_nxt   = rec_r;
    rst_nxt   = rst_r;
    mask_nxt  = mask_r;
    rdata_nxt = rdata_r;
    st_nxt    = st_r;
    idx_nxt   = idx_r;
    snap_nxt  = snap_r;
    nv_nxt    = nv_r;
    if (wr_rec)
    begin
      rec_nxt.enable     = reg_wdata_in[FRR_REC_EN_BIT];
      rec_nxt.unlock     = reg_wdata_in[FRR_REC_UNLOCK_BIT];
      rec_nxt.alert_mask = reg_wdata_in[FRR_REC_ALERT_BIT];
      if (permit && !reg_wdata_in[FRR_REC_BEGUN_BIT])
        rec_nxt.begun = 1'b0;
      if (permit && !reg_wdata_in[FRR_REC_DONE_BIT])
        rec_nxt.done = 1'b0;
    end
    if (wr_rst)
    begin
      rst_nxt.auto_restart_enable    = reg_wdata_in[FRR_RST_EN_BIT];
      rst_nxt.auto_restart_delay_sel = reg_wdata_in[FRR_RST_DL_LSB+2:FRR_RST_DL_LSB];
    end
    if (reg_wr_in && mask_hit(reg_addr_in))
      mask_nxt[mask_idx(reg_addr_in)] = reg_wdata_in;
    if (reg_rd_in)
    begin
      if (reg_addr_in == FRR_REC_CTL_OFS)
        rdata_nxt = rec_rd;
      else if (reg_addr_in == FRR_RESTART_OFS)
        rdata_nxt = rst_rd;
      else if (mask_hit(reg_addr_in))
        rdata_nxt = mask_r[mask_idx(reg_addr_in)];
      else
        rdata_nxt = 8'h00;
    end
    // Hardware sets after the host clear so a same-cycle event is kept
    unique case (st_r)
      FRR_REC_IDLE:
        if (rec_start)
        begin
          rec_nxt.begun = 1'b1;
          snap_nxt      = {meas_msb_in, alarm_flags_in, fault_flags_in};
          idx_nxt       = 4'h0;
          nv_nxt.addr   = nv_addr(4'h0);
          nv_nxt.data   = fault_flags_in;
          st_nxt        = FRR_REC_COPY;
        end
      FRR_REC_COPY:
        if (nv_ack_in)
        begin
          if (rec_last)
          begin
            rec_nxt.done = 1'b1;
            st_nxt       = FRR_REC_IDLE;
          end
          else
          begin
            idx_nxt     = idx_r + 4'h1;
            nv_nxt.addr = nv_addr(idx_r + 4'h1);
            nv_nxt.data = snap_r[idx_r + 4'h1];
          end
        end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rec_r   <= '0;
      rst_r   <= '0;
      mask_r  <= {FRR_MASK_REGS{FRR_MASK_RST}};
      rdata_r <= 8'h00;
      st_r    <= FRR_REC_IDLE;
      idx_r   <= 4'h0;
      snap_r  <= '0;
      nv_r    <= '0;
    end
    else if (ce_in)
    begin
      rec_r   <= rec_nxt;
      rst_r   <= rst_nxt;
      mask_r  <= mask_nxt;
      rdata_r <= rdata_nxt;
      st_r    <= st_nxt;
      idx_r   <= idx_nxt;
      snap_r  <= snap_nxt;
      nv_r    <= nv_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign nv_req_out    = (st_r == FRR_REC_COPY);
  assign nv_out        = nv_r;

  // ****************************************
  // Alert gating
  // ****************************************
  assign alert_req_out = |(fault_flags_in & mask_r[0]) ||
                         |(alarm_flags_in & mask_r[FRR_MASK_REGS-1:1]) ||
                         |(meter_flags_in & meter_alert_mask_in) ||
                         (conv_done_in && conversion_alert_mask_in) ||
                         (rec_r.done && rec_r.alert_mask);

  // ****************************************
  // Auto-restart timer
  // ****************************************
  // Enable is cleared only by the host, so each later command restarts again until the host clears it
  always_comb
  begin
    cnt_on_nxt = cnt_on_r;
    cnt_nxt    = cnt_r;
    on_nxt     = 1'b0;
    if (restart_cmd_in && rst_r.auto_restart_enable)
    begin
      cnt_on_nxt = 1'b1;
      cnt_nxt    = 32'(RESTART_BASE_CYC) << rst_r.auto_restart_delay_sel;
    end
    else if (cnt_on_r && !rst_r.auto_restart_enable)
      cnt_on_nxt = 1'b0;
    else if (cnt_on_r)
    begin
      if (cnt_r <= 32'h1)
      begin
        cnt_on_nxt = 1'b0;
        on_nxt     = 1'b1;
      end
      else
        cnt_nxt = cnt_r - 32'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_on_r <= 1'b0;
      cnt_r    <= 32'h0;
      on_r     <= 1'b0;
    end
    else if (ce_in)
    begin
      cnt_on_r <= cnt_on_nxt;
      cnt_r    <= cnt_nxt;
      on_r     <= on_nxt;
    end
  end

  assign turn_on_out = on_r;

  // ****************************************
  // Assertions
  // ****************************************
  sequence rec_kick_s;
    ce_in && rec_start;
  endsequence

  sequence rec_first_s;
    nv_req_out && (nv_out.addr == FRR_NV_FLAG_BASE) && rec_r.begun;
  endsequence

  rec_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
    rec_kick_s |=> rec_first_s) else $error("record did not start");
  en_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rec_r.enable) |-> $past(wr_rec && ce_in)) else $error("enable cleared");
  clear_permit_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ($fell(rec_r.begun) || $fell(rec_r.done)) |-> $past(wr_rec && permit))
    else $error("flag cleared without permit");
  begun_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(rec_r.begun) |-> $past(rec_start)) else $error("begun set by host");
  done_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(rec_r.done) |-> $past(rec_last) && !nv_req_out)
    else $error("done without copy end");
  rec_alert_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (rec_r.done && rec_r.alert_mask) |-> alert_req_out) else $error("no record alert");
  rsvd_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(reg_rd_in && ce_in && reg_addr_in == FRR_REC_CTL_OFS) |-> reg_rdata_out[2:0] == 3'h0)
    else $error("reserved bits not zero");
  meas_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (nv_req_out && idx_r == 4'h6) |-> nv_out.addr == FRR_NV_MEAS_BASE)
    else $error("bad result addr");
  // Only a host write may drop the enable around the turn-on pulse
  restart_en_a: assert property (@(posedge clk_in) disable iff (rst_in)
    turn_on_out |-> (rst_r.auto_restart_enable || $past(wr_rst && ce_in)) ##1
      (rst_r.auto_restart_enable || $past(wr_rst && ce_in))) else $error("restart enable lost");
  holdoff_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (ce_in && restart_cmd_in && rst_r.auto_restart_enable) |=> rst_rd[1] && !turn_on_out)
    else $error("holdoff not shown");
  wp_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(reg_rd_in && ce_in && reg_addr_in == FRR_RESTART_OFS) |->
      reg_rdata_out[FRR_RST_WP_BIT] == $past(wp_pin_in)) else $error("write-protect flag wrong");
  no_rearm_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(nv_req_out) |-> $past(!rec_r.begun && !rec_r.done)) else $error("record restarted");

endmodule

// [frr_nv_model.sv]
// Behavioural nonvolatile write engine that sits on the record port.
// Assumes the record port holds address and data until it sees an ack.
`timescale 1ns/1ns
module frr_nv_model
  import frr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       req_in,
  input  wire frr_nv_s    nv_in,
  input  wire logic [3:0] stall_in,
  output logic            ack_out
);
  // ****************************************
  // Byte store with a settable stall
  // ****************************************
  logic [7:0] mem [256];
  logic [3:0] wait_r;

  // Ack only while a request stands, so a late ack never leaks into idle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ack_out <= 1'b0;
      wait_r  <= 4'h0;
    end
    else if (req_in && !ack_out && wait_r >= stall_in)
    begin
      ack_out           <= 1'b1;
      wait_r            <= 4'h0;
      mem[nv_in.addr]   <= nv_in.data;
    end
    else
    begin
      ack_out <= 1'b0;
      wait_r  <= (req_in && !ack_out) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

// [frr_regs_tb_top.sv]
// Self-checking bench for the fault record, restart and alert registers.
// Assumes frr_pkg, frr_regs and frr_nv_model are compiled before it.
`timescale 1ns/1ns
module frr_regs_tb_top
  import frr_pkg::*;
;
  // ****************************************
  // Stimulus and wiring
  // ****************************************
  logic            clk_in = 1'b0;
  logic            rst_in = 1'b1;
  logic [7:0]      addr = 8'h00, wdata = 8'h00, rdata;
  logic            wr = 1'b0, rd = 1'b0, fault = 1'b0, ack, nv_req, alert, turn_on;
  logic [7:0]      flags [6];
  logic [4:0][7:0] alarm;
  logic [5:0][7:0] meas;
  logic [1:0]      mflag = 2'b00, mmask = 2'b00;
  logic            conv = 1'b0, cmask = 1'b0, cmd = 1'b0, cool = 1'b0, wp = 1'b1;
  logic            latch = 1'b0, ce = 1'b1;
  logic [3:0]      stall = 4'h0;
  frr_nv_s         nv;
  int              fails = 0, samples_checked = 0, n;
  logic [23:0]     rows [5] = '{24'h90ffc8, 24'ha2fff1, 24'h15a5a5, 24'h1a3c3c, 24'h33ff00};

  always #50 clk_in = ~clk_in;
  assign alarm = {flags[5], flags[4], flags[3], flags[2], flags[1]};

  frr_regs #(.RESTART_BASE_CYC(4)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .fault_event_in(fault), .fault_flags_in(flags[0]), .alarm_flags_in(alarm),
    .meas_msb_in(meas), .nv_req_out(nv_req), .nv_out(nv), .nv_ack_in(ack),
    .meter_flags_in(mflag), .meter_alert_mask_in(mmask), .conv_done_in(conv),
    .conversion_alert_mask_in(cmask), .alert_req_out(alert),
    .restart_cmd_in(cmd), .cooling_in(cool), .latchoff_in(latch),
    .turn_on_out(turn_on), .wp_pin_in(wp));

  frr_nv_model u_nv (.clk_in(clk_in), .rst_in(rst_in), .req_in(nv_req), .nv_in(nv),
    .stall_in(stall), .ack_out(ack));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in) {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk_in) wr = 1'b0;
  endtask

  task automatic rdb(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in) {rd, addr} = {1'b1, a};
    @(negedge clk_in) rd = 1'b0;
    chk(rdata, exp);
  endtask

  // Fault pulse, then wait for the copy to finish within a bound
  task automatic record();
    @(negedge clk_in) fault = 1'b1;
    @(negedge clk_in) fault = 1'b0;
    for (n = 0; n < 300 && nv_req; n++)
      @(negedge clk_in);
    if (n == 300)
    begin
      fails++;
      close_out();
    end
  endtask

  // Counts cycles from the taken command edge to the turn-on pulse
  task automatic restart(input int lim);
    @(negedge clk_in) cmd = 1'b1;
    @(negedge clk_in) cmd = 1'b0;
    for (n = 0; n < lim && !turn_on; n++)
      @(negedge clk_in);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    for (int i = 0; i < 6; i++)
    begin
      flags[i] = 8'h00;
      meas[i]  = 8'h40 + 8'(i);
    end
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    wp = 1'b0;
    rdb(FRR_REC_CTL_OFS, FRR_REC_CTL_RST);
    rdb(FRR_RESTART_OFS, FRR_RESTART_RST);
    wp = 1'b1;
    foreach (rows[i])
    begin
      wrb(rows[i][23:16], rows[i][15:8]);
      rdb(rows[i][23:16], rows[i][7:0]);
    end
    wrb(8'h15, 8'h00);
    wrb(8'h1a, 8'h00);
    // Each flag byte is gated by its own mask register only
    for (int i = 0; i < FRR_MASK_REGS; i++)
    begin
      flags[i] = 8'h81;
      wrb(FRR_MASK_BASE_OFS + 8'(i), 8'h02);
      chk({7'h00, alert}, 8'h00);
      wrb(FRR_MASK_BASE_OFS + 8'(i), 8'h01);
      chk({7'h00, alert}, 8'h01);
      wrb(FRR_MASK_BASE_OFS + 8'(i), 8'h00);
      flags[i] = 8'h00;
    end
    {mflag, mmask, conv} = {2'b10, 2'b01, 1'b1};
    @(negedge clk_in) chk({7'h00, alert}, 8'h00);
    {mmask, cmask} = {2'b10, 1'b0};
    @(negedge clk_in) chk({7'h00, alert}, 8'h01);
    {mmask, cmask} = {2'b00, 1'b1};
    @(negedge clk_in) chk({7'h00, alert}, 8'h01);
    {mflag, conv, cmask} = 4'h0;
    // Record with alert mask set and a stalling engine
    wrb(FRR_REC_CTL_OFS, 8'h88);
    for (int i = 0; i < 6; i++)
      flags[i] = 8'h10 + 8'(i);
    stall = 4'h3;
    record();
    for (int i = 0; i < 6; i++)
    begin
      chk(u_nv.mem[FRR_NV_FLAG_BASE + 8'(i)], 8'h10 + 8'(i));
      chk(u_nv.mem[FRR_NV_MEAS_BASE + 8'(i)], 8'h40 + 8'(i));
      flags[i] = 8'h00;
    end
    rdb(FRR_REC_CTL_OFS, 8'hb8);
    chk({7'h00, alert}, 8'h01);
    flags[0] = 8'h5a;
    record();
    chk(u_nv.mem[FRR_NV_FLAG_BASE], 8'h10);
    wrb(FRR_REC_CTL_OFS, 8'h80);
    rdb(FRR_REC_CTL_OFS, 8'hb0);
    chk({7'h00, alert}, 8'h00);
    wrb(FRR_REC_CTL_OFS, 8'hc0);
    rdb(FRR_REC_CTL_OFS, 8'hc0);
    stall = 4'h0;
    record();
    chk(u_nv.mem[FRR_NV_FLAG_BASE], 8'h5a);
    rdb(FRR_REC_CTL_OFS, 8'hf0);
    chk({7'h00, alert}, 8'h00);
    // Every delay code, host clearing enable between commands
    for (int s = 0; s < 8; s++)
    begin
      wrb(FRR_RESTART_OFS, 8'h80 | 8'(s << 4));
      restart(1000);
      if (n == 1000)
      begin
        fails++;
        close_out();
      end
      chk(8'(n), 8'(4 << s));
      chk(8'(n >> 8), 8'((4 << s) >> 8));
      rdb(FRR_RESTART_OFS, 8'h81 | 8'(s << 4));
      wrb(FRR_RESTART_OFS, 8'h00);
    end
    restart(60);
    chk(8'(n), 8'd60);
    cool = 1'b1;
    rdb(FRR_RESTART_OFS, 8'h03);
    cool = 1'b0;
    rdb(FRR_RESTART_OFS, 8'h01);
    latch = 1'b1;
    rdb(FRR_RESTART_OFS, 8'h03);
    latch = 1'b0;
    // Clock enable low must freeze the register file
    ce = 1'b0;
    wrb(FRR_MASK_BASE_OFS, 8'h77);
    ce = 1'b1;
    rdb(FRR_MASK_BASE_OFS, 8'h00);
    close_out();
  end
endmodule
